//--- verilog/lfw_map.svh
// Notes on behaviour
// - Mode 10 with burst preamble: after preamble, need start burst then gap before sync.
// - Sync on falling envelope edge of first burst after gap; then 7+16 Manchester bits.
// - With wake mask set, wake interrupt rises at final bit of matching sequence.
// - After a match, data is packed into bytes; each byte raises buffer interrupt if masked in.
// - No valid burst, header, identifier, or a data gap over 2.03 ms returns to standby.
// - Clearing receiver enable forces standby from any progress.
// - Start burst 48..200 periods, gap 10..100 periods, sync burst one bit to 200 periods.
// - Mode 11 is transparent: demodulated envelope goes out as a capture input.
// - In transparent mode the oscillator and demodulated output start together at preamble.
// - Transparent mode never returns to standby by itself; front-end reset re-arms.
// - Switching mode to 11 mid-session moves to transparent state; switching back later leaves it transparent.
// - Buffer full flag sets on byte load; clears on vector or write-one.
// - Wake flag sets on wake-up; clears on vector or write-one.
// - Rising edge at mid-bit decodes as one; sender keeps 3.90625 kb/s within 300 b/s.
`ifndef LFW_MAP_SVH
`define LFW_MAP_SVH

`define LFW_CLK_PERIOD_NS 100
`define LFW_CYC_UP(t_us) ((((t_us) * 1000) + `LFW_CLK_PERIOD_NS - 1) / `LFW_CLK_PERIOD_NS)
`define LFW_CYC_DN(t_us) (((t_us) * 1000) / `LFW_CLK_PERIOD_NS)

`define LFW_T_SB_MIN_US 593
`define LFW_T_SB_MAX_US 2030
`define LFW_T_GAP_MIN_US 124
`define LFW_T_SBG_MAX_US 1015
`define LFW_T_SG_MAX_US 2030
`define LFW_T_SBB_MIN_US 256
`define LFW_T_SBB_MAX_US 2030
`define LFW_T_DATA_GAP_US 2030
`define LFW_T_BIT_US 256

`define LFW_GAP_MIN_CYC `LFW_CYC_UP(`LFW_T_GAP_MIN_US)
`define LFW_SBB_MIN_CYC `LFW_CYC_UP(`LFW_T_SBB_MIN_US)
`define LFW_BIT_CYC `LFW_CYC_DN(`LFW_T_BIT_US)
`define LFW_MID_MIN_CYC ((`LFW_BIT_CYC * 3) / 4)

`define LFW_HDR_BITS 7
`define LFW_ID_BITS 16
`define LFW_FRAME_BITS 8
`define LFW_MODE_HDR 2'b01
`define LFW_MODE_HDR_ID 2'b10
`define LFW_MODE_TRANSP 2'b11

`endif

//--- verilog/lfw_pkg.sv
package lfw_pkg;

    typedef struct packed {
        logic receiver_enable_bit;
        logic [1:0] wake_mode_field;
        logic burst_preamble_select;
        logic wake_irq_mask_bit;
        logic buffer_irq_mask_bit;
    } lfw_ctrl_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_START_BURST = 3'b001,
        ST_START_GAP = 3'b011,
        ST_SYNC_BURST = 3'b010,
        ST_MATCH = 3'b110,
        ST_DATA = 3'b111,
        ST_TRANSP = 3'b101
    } lfw_state_t;

endpackage : lfw_pkg

//--- verilog/lfw_manch_rx.sv
`timescale 1ns/1ns
`include "lfw_map.svh"

module lfw_manch_rx import lfw_pkg::*;
#(
    parameter logic [15:0] MID_MIN_CYC = 16'(`LFW_MID_MIN_CYC),
    parameter logic [15:0] GAP_MAX_CYC = 16'(`LFW_CYC_DN(`LFW_T_DATA_GAP_US))
)
(
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_start,
    input wire logic i_stop,
    input wire logic i_rise,
    input wire logic i_fall,
    output logic o_bit_valid,
    output logic o_bit,
    output logic o_gap
);

    logic active_reg;
    logic active_next;
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;

    // -------------------------------------------------------------------
    // Mid-bit edge detection
    // -------------------------------------------------------------------
    // The sync edge is taken as a mid-bit reference; edges closer than
    // three quarters of a bit to the previous mid-bit edge are boundaries.
    always_comb
    begin
        active_next = active_reg;
        cnt_next = (cnt_reg == 16'hFFFF) ? cnt_reg : cnt_reg + 16'h0001;
        o_bit_valid = 1'b0;
        o_bit = i_rise;
        o_gap = 1'b0;
        if (!active_reg)
        begin
            cnt_next = 16'h0000;
        end
        else if ((i_rise || i_fall) && (cnt_reg >= MID_MIN_CYC))
        begin
            o_bit_valid = 1'b1;
            cnt_next = 16'h0000;
        end
        else if (cnt_reg > GAP_MAX_CYC)
        begin
            o_gap = 1'b1;
            active_next = 1'b0;
        end
        if (i_stop)
        begin
            active_next = 1'b0;
        end
        if (i_start)
        begin
            active_next = 1'b1;
            cnt_next = 16'h0000;
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            active_reg <= 1'b0;
            cnt_reg <= 16'h0000;
        end
        else
        begin
            active_reg <= active_next;
            cnt_reg <= cnt_next;
        end
    end

endmodule : lfw_manch_rx

//--- verilog/lfw_sequencer.sv
`timescale 1ns/1ns
`include "lfw_map.svh"

module lfw_sequencer import lfw_pkg::*;
#(
    parameter logic [15:0] SB_MIN_CYC = 16'(`LFW_CYC_UP(`LFW_T_SB_MIN_US)),
    parameter logic [15:0] SB_MAX_CYC = 16'(`LFW_CYC_DN(`LFW_T_SB_MAX_US)),
    parameter logic [15:0] SBG_MAX_CYC = 16'(`LFW_CYC_DN(`LFW_T_SBG_MAX_US)),
    parameter logic [15:0] SG_MAX_CYC = 16'(`LFW_CYC_DN(`LFW_T_SG_MAX_US)),
    parameter logic [15:0] SBB_MAX_CYC = 16'(`LFW_CYC_DN(`LFW_T_SBB_MAX_US)),
    parameter logic [15:0] DATA_GAP_CYC = 16'(`LFW_CYC_DN(`LFW_T_DATA_GAP_US))
)
(
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_envelope,
    input wire logic i_preamble_det,
    input wire lfw_ctrl_t i_ctrl,
    input wire logic [6:0] i_header_pattern,
    input wire logic [15:0] i_ident_pattern,
    input wire logic i_frontend_reset_bit,
    input wire logic i_wake_vector_ack,
    input wire logic i_buffer_vector_ack,
    input wire logic i_wake_flag_w1c,
    input wire logic i_buffer_flag_w1c,
    output logic o_wake_interrupt,
    output logic o_rx_buffer_interrupt,
    output logic o_wake_flag,
    output logic o_buffer_full_flag,
    output logic [7:0] o_receive_buffer,
    output logic o_demodulated_out,
    output logic o_slow_rc_oscillator_en,
    output lfw_state_t o_state
);

    localparam int SEQ_BITS = `LFW_HDR_BITS + `LFW_ID_BITS;

    // -------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------
    // Number of Manchester bits to compare before wake-up.
    function automatic logic [4:0] match_len(input logic [1:0] mode);
        logic [4:0] len;
        len = 5'h00;
        if (mode == `LFW_MODE_HDR)
        begin
            len = 5'(`LFW_HDR_BITS);
        end
        else if (mode == `LFW_MODE_HDR_ID)
        begin
            len = 5'(SEQ_BITS);
        end
        return len;
    endfunction : match_len

    function automatic logic match_ok(input logic [1:0] mode, input logic [SEQ_BITS-1:0] seq,
                                      input logic [6:0] hdr, input logic [15:0] ident);
        logic ok;
        ok = 1'b0;
        if (mode == `LFW_MODE_HDR)
        begin
            ok = (seq[6:0] == hdr);
        end
        else if (mode == `LFW_MODE_HDR_ID)
        begin
            ok = (seq == {hdr, ident});
        end
        return ok;
    endfunction : match_ok

    // -------------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------------
    logic env_meta_reg;
    logic env_sync_reg;
    logic env_prev_reg;
    logic pre_meta_reg;
    logic pre_sync_reg;
    logic pre_prev_reg;

    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            env_meta_reg <= 1'b0;
            env_sync_reg <= 1'b0;
            env_prev_reg <= 1'b0;
            pre_meta_reg <= 1'b0;
            pre_sync_reg <= 1'b0;
            pre_prev_reg <= 1'b0;
        end
        else
        begin
            env_meta_reg <= i_envelope;
            env_sync_reg <= env_meta_reg;
            env_prev_reg <= env_sync_reg;
            pre_meta_reg <= i_preamble_det;
            pre_sync_reg <= pre_meta_reg;
            pre_prev_reg <= pre_sync_reg;
        end
    end

    logic env_rise;
    logic env_fall;
    logic pre_rise;

    assign env_rise = env_sync_reg & ~env_prev_reg;
    assign env_fall = ~env_sync_reg & env_prev_reg;
    assign pre_rise = pre_sync_reg & ~pre_prev_reg;

    // -------------------------------------------------------------------
    // Manchester bit decoder
    // -------------------------------------------------------------------
    logic dec_start;
    logic dec_stop;
    logic dec_bit_valid;
    logic dec_bit;
    logic dec_gap;

    lfw_manch_rx #(
        .MID_MIN_CYC(16'(`LFW_MID_MIN_CYC)),
        .GAP_MAX_CYC(DATA_GAP_CYC)
    ) u_manch_rx (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_start(dec_start),
        .i_stop(dec_stop),
        .i_rise(env_rise),
        .i_fall(env_fall),
        .o_bit_valid(dec_bit_valid),
        .o_bit(dec_bit),
        .o_gap(dec_gap)
    );

    // -------------------------------------------------------------------
    // Wake-up sequencer
    // -------------------------------------------------------------------
    lfw_state_t state_reg;
    lfw_state_t state_next;
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic [SEQ_BITS-1:0] shift_reg;
    logic [SEQ_BITS-1:0] shift_next;
    logic [4:0] bits_reg;
    logic [4:0] bits_next;
    logic [7:0] rxbuf_reg;
    logic [7:0] rxbuf_next;
    logic wake_flag_reg;
    logic wake_flag_next;
    logic buf_flag_reg;
    logic buf_flag_next;
    logic wake_irq_reg;
    logic wake_irq_next;
    logic buf_irq_reg;
    logic buf_irq_next;
    logic demod_reg;
    logic demod_next;
    logic osc_reg;
    logic osc_next;
    logic wake_set;
    logic buf_set;
    logic [4:0] len;
    logic [4:0] bits_inc;
    logic [15:0] gap_max;
    logic transp_mode;

    assign len = match_len(i_ctrl.wake_mode_field);
    assign bits_inc = bits_reg + 5'h01;
    assign gap_max = i_ctrl.burst_preamble_select ? SBG_MAX_CYC : SG_MAX_CYC;
    assign transp_mode = (i_ctrl.wake_mode_field == `LFW_MODE_TRANSP);

    always_comb
    begin
        state_next = state_reg;
        cnt_next = (cnt_reg == 16'hFFFF) ? cnt_reg : cnt_reg + 16'h0001;
        shift_next = shift_reg;
        bits_next = bits_reg;
        rxbuf_next = rxbuf_reg;
        wake_set = 1'b0;
        buf_set = 1'b0;
        dec_start = 1'b0;
        unique case (state_reg)
            ST_IDLE:
            begin
                cnt_next = 16'h0000;
                if (pre_rise)
                begin
                    if (transp_mode)
                    begin
                        state_next = ST_TRANSP;
                    end
                    else if (i_ctrl.burst_preamble_select)
                    begin
                        state_next = ST_START_BURST;
                    end
                    else
                    begin
                        state_next = ST_START_GAP;
                    end
                end
            end
            ST_START_BURST:
            begin
                if (env_rise)
                begin
                    cnt_next = 16'h0000;
                end
                else if (env_fall)
                begin
                    cnt_next = 16'h0000;
                    if (cnt_reg >= SB_MIN_CYC)
                    begin
                        state_next = ST_START_GAP;
                    end
                    else
                    begin
                        state_next = ST_IDLE;
                    end
                end
                else if (cnt_reg > SB_MAX_CYC)
                begin
                    state_next = ST_IDLE;
                end
            end
            ST_START_GAP:
            begin
                if (env_rise)
                begin
                    cnt_next = 16'h0000;
                    if (cnt_reg >= 16'(`LFW_GAP_MIN_CYC))
                    begin
                        state_next = ST_SYNC_BURST;
                    end
                    else
                    begin
                        state_next = ST_IDLE;
                    end
                end
                else if (env_sync_reg)
                begin
                    cnt_next = 16'h0000;
                end
                else if (cnt_reg > gap_max)
                begin
                    state_next = ST_IDLE;
                end
            end
            ST_SYNC_BURST:
            begin
                if (env_fall)
                begin
                    if (cnt_reg >= 16'(`LFW_SBB_MIN_CYC))
                    begin
                        dec_start = 1'b1;
                        shift_next = '0;
                        bits_next = 5'h00;
                        if (len == 5'h00)
                        begin
                            wake_set = 1'b1;
                            state_next = ST_DATA;
                        end
                        else
                        begin
                            state_next = ST_MATCH;
                        end
                    end
                    else
                    begin
                        state_next = ST_IDLE;
                    end
                end
                else if (cnt_reg > SBB_MAX_CYC)
                begin
                    state_next = ST_IDLE;
                end
            end
            ST_MATCH:
            begin
                if (dec_gap)
                begin
                    state_next = ST_IDLE;
                end
                else if (dec_bit_valid)
                begin
                    shift_next = {shift_reg[SEQ_BITS-2:0], dec_bit};
                    bits_next = bits_inc;
                    if (bits_inc >= len)
                    begin
                        bits_next = 5'h00;
                        if (match_ok(i_ctrl.wake_mode_field, shift_next, i_header_pattern, i_ident_pattern))
                        begin
                            wake_set = 1'b1;
                            state_next = ST_DATA;
                        end
                        else
                        begin
                            state_next = ST_IDLE;
                        end
                    end
                end
            end
            ST_DATA:
            begin
                if (dec_gap)
                begin
                    state_next = ST_IDLE;
                end
                else if (dec_bit_valid)
                begin
                    shift_next = {shift_reg[SEQ_BITS-2:0], dec_bit};
                    bits_next = bits_inc;
                    if (bits_inc == 5'(`LFW_FRAME_BITS))
                    begin
                        bits_next = 5'h00;
                        rxbuf_next = {shift_reg[6:0], dec_bit};
                        buf_set = 1'b1;
                    end
                end
            end
            ST_TRANSP:
            begin
                if (i_frontend_reset_bit)
                begin
                    state_next = ST_IDLE;
                end
            end
        endcase
        // A session in progress carries over into transparent operation.
        if (transp_mode && (state_reg != ST_IDLE) && (state_next != ST_IDLE))
        begin
            state_next = ST_TRANSP;
        end
        if (!i_ctrl.receiver_enable_bit)
        begin
            state_next = ST_IDLE;
        end
    end

    assign dec_stop = (state_next != ST_MATCH) && (state_next != ST_DATA);

    // -------------------------------------------------------------------
    // Flags, interrupts and front-end outputs
    // -------------------------------------------------------------------
    always_comb
    begin
        wake_flag_next = wake_set | (wake_flag_reg & ~(i_wake_vector_ack | i_wake_flag_w1c));
        buf_flag_next = buf_set | (buf_flag_reg & ~(i_buffer_vector_ack | i_buffer_flag_w1c));
        wake_irq_next = wake_flag_next & i_ctrl.wake_irq_mask_bit;
        buf_irq_next = buf_flag_next & i_ctrl.buffer_irq_mask_bit;
        osc_next = (state_next == ST_TRANSP);
        demod_next = (state_next == ST_TRANSP) & env_sync_reg;
    end

    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_reg <= ST_IDLE;
            cnt_reg <= 16'h0000;
            shift_reg <= '0;
            bits_reg <= 5'h00;
            rxbuf_reg <= 8'h00;
            wake_flag_reg <= 1'b0;
            buf_flag_reg <= 1'b0;
            wake_irq_reg <= 1'b0;
            buf_irq_reg <= 1'b0;
            demod_reg <= 1'b0;
            osc_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            shift_reg <= shift_next;
            bits_reg <= bits_next;
            rxbuf_reg <= rxbuf_next;
            wake_flag_reg <= wake_flag_next;
            buf_flag_reg <= buf_flag_next;
            wake_irq_reg <= wake_irq_next;
            buf_irq_reg <= buf_irq_next;
            demod_reg <= demod_next;
            osc_reg <= osc_next;
        end
    end

    assign o_wake_interrupt = wake_irq_reg;
    assign o_rx_buffer_interrupt = buf_irq_reg;
    assign o_wake_flag = wake_flag_reg;
    assign o_buffer_full_flag = buf_flag_reg;
    assign o_receive_buffer = rxbuf_reg;
    assign o_demodulated_out = demod_reg;
    assign o_slow_rc_oscillator_en = osc_reg;
    assign o_state = state_reg;

endmodule : lfw_sequencer

//--- test/lfw_sequencer_assertions.sv
`timescale 1ns/1ns

module lfw_seq_chk import lfw_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire lfw_ctrl_t i_ctrl,
    input wire logic i_frontend_reset_bit,
    input wire logic i_wake_vector_ack,
    input wire logic i_wake_flag_w1c,
    input wire logic i_buffer_vector_ack,
    input wire logic i_buffer_flag_w1c,
    input wire logic o_wake_interrupt,
    input wire logic o_rx_buffer_interrupt,
    input wire logic o_wake_flag,
    input wire logic o_buffer_full_flag,
    input wire logic [7:0] o_receive_buffer,
    input wire logic o_demodulated_out,
    input wire logic o_slow_rc_oscillator_en,
    input wire lfw_state_t o_state
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rstn);

    sequence wake_clr_s;
        i_wake_vector_ack || i_wake_flag_w1c;
    endsequence

    sequence buf_clr_s;
        i_buffer_vector_ack || i_buffer_flag_w1c;
    endsequence

    wake_irq_a: assert property (o_wake_interrupt == (o_wake_flag && $past(i_ctrl.wake_irq_mask_bit)))
        else $error("wake interrupt does not follow flag and mask");
    buf_irq_a: assert property (o_rx_buffer_interrupt == (o_buffer_full_flag && $past(i_ctrl.buffer_irq_mask_bit)))
        else $error("buffer interrupt does not follow flag and mask");
    disable_idle_a: assert property (!i_ctrl.receiver_enable_bit |=> o_state == ST_IDLE)
        else $error("disabled receiver not in standby");
    osc_transp_a: assert property (o_slow_rc_oscillator_en == (o_state == ST_TRANSP))
        else $error("oscillator enable differs from transparent state");
    demod_quiet_a: assert property (o_state != ST_TRANSP |-> !o_demodulated_out)
        else $error("demodulated output active outside transparent state");
    transp_hold_a: assert property ((o_state == ST_TRANSP && i_ctrl.receiver_enable_bit && !i_frontend_reset_bit)
        |=> o_state == ST_TRANSP)
        else $error("transparent state left on its own");
    fe_reset_a: assert property ((o_state == ST_TRANSP && i_frontend_reset_bit) |=> o_state == ST_IDLE)
        else $error("front-end reset did not return to standby");
    wake_rise_a: assert property ($rose(o_wake_flag) |-> o_state == ST_DATA)
        else $error("wake flag set outside data reception");
    buf_load_a: assert property ($changed(o_receive_buffer) |-> o_buffer_full_flag && o_state == ST_DATA)
        else $error("buffer loaded without full flag");
    wake_clear_a: assert property (wake_clr_s ##1 $stable(o_state) |-> !o_wake_flag)
        else $error("wake flag not cleared");
    buf_clear_a: assert property (buf_clr_s ##1 $stable(o_receive_buffer) |-> !o_buffer_full_flag)
        else $error("buffer full flag not cleared");
endmodule : lfw_seq_chk

bind lfw_sequencer lfw_seq_chk u_chk (.i_clock(i_clock), .i_rstn(i_rstn), .i_ctrl(i_ctrl),
    .i_frontend_reset_bit(i_frontend_reset_bit), .i_wake_vector_ack(i_wake_vector_ack),
    .i_wake_flag_w1c(i_wake_flag_w1c), .i_buffer_vector_ack(i_buffer_vector_ack),
    .i_buffer_flag_w1c(i_buffer_flag_w1c), .o_wake_interrupt(o_wake_interrupt),
    .o_rx_buffer_interrupt(o_rx_buffer_interrupt), .o_wake_flag(o_wake_flag),
    .o_buffer_full_flag(o_buffer_full_flag), .o_receive_buffer(o_receive_buffer),
    .o_demodulated_out(o_demodulated_out), .o_slow_rc_oscillator_en(o_slow_rc_oscillator_en), .o_state(o_state));

//--- test/lfw_tx_model.sv
`timescale 1ns/1ns

module lfw_tx_model
(
    input wire logic i_clock,
    output logic o_envelope,
    output logic o_preamble_det
);
    initial o_envelope = 1'h0;
    initial o_preamble_det = 1'h0;

    task preamble(input logic lvl);
        o_preamble_det = lvl;
    endtask : preamble

    // Carrier level for a number of clocks; burst and gap lengths come from the caller.
    task hold(input logic lvl, input int n);
        o_envelope = lvl;
        repeat (n) @(posedge i_clock);
        #1;
    endtask : hold

    // One Manchester bit of 2560 clocks; the mid-bit edge rises for a one.
    task bit_out(input logic b);
        hold(~b, 1280);
        hold(b, 1280);
    endtask : bit_out
endmodule : lfw_tx_model

//--- test/lfw_sequencer_tb.sv
`timescale 1ns/1ns

module lfw_sequencer_tb import lfw_pkg::*;
;
    logic i_clock = 1'h0;
    logic i_rstn = 1'h0;
    wire logic env;
    wire logic pre;
    lfw_ctrl_t ctrl = 6'h3F;
    logic fe_rst = 1'h0;
    logic w_ack = 1'h0;
    logic b_ack = 1'h0;
    logic w_w1c = 1'h0;
    logic b_w1c = 1'h0;
    logic w_irq, b_irq, w_flag, b_flag, demod, osc;
    logic [7:0] rx_byte;
    lfw_state_t state;
    logic [22:0] pattern = {7'h35, 16'hC3A5};
    int n_errors = 0;
    int comparisons = 0;

    always #50 i_clock = ~i_clock;

    lfw_tx_model tx (.i_clock(i_clock), .o_envelope(env), .o_preamble_det(pre));

    lfw_sequencer #(.SB_MIN_CYC(16'h003C), .DATA_GAP_CYC(16'h0FA0)) DUT (.i_clock(i_clock), .i_rstn(i_rstn),
        .i_envelope(env), .i_preamble_det(pre), .i_ctrl(ctrl), .i_header_pattern(pattern[22:16]),
        .i_ident_pattern(pattern[15:0]), .i_frontend_reset_bit(fe_rst), .i_wake_vector_ack(w_ack),
        .i_buffer_vector_ack(b_ack), .i_wake_flag_w1c(w_w1c), .i_buffer_flag_w1c(b_w1c),
        .o_wake_interrupt(w_irq), .o_rx_buffer_interrupt(b_irq), .o_wake_flag(w_flag),
        .o_buffer_full_flag(b_flag), .o_receive_buffer(rx_byte), .o_demodulated_out(demod),
        .o_slow_rc_oscillator_en(osc), .o_state(state));

    task print_verdict;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
        begin
            $display("bench passed");
        end
        else
        begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    task check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task cyc(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask : cyc

    task wait_state(input lfw_state_t st, input int lim);
        int i;
        for (i = 0; i < lim && state !== st; i++)
            cyc(1);
        if (state !== st)
        begin
            n_errors++;
            print_verdict();
        end
    endtask : wait_state

    // Burst preamble, then start burst of the given length; the caller adds gap and sync burst.
    task start_frame(input int burst);
        tx.preamble(1'h1);
        tx.hold(1'h0, 5);
        check(16'(state), 16'(ST_START_BURST));
        tx.hold(1'h1, burst);
    endtask : start_frame

    task s_wake_data;
        int i;
        start_frame(100);
        tx.hold(1'h0, 1300);
        tx.hold(1'h1, 2700);
        tx.hold(1'h0, 1280);
        for (i = 22; i >= 0; i--)
        begin
            if (i == 0)
                check(16'(w_flag), 16'h0000);
            tx.bit_out(pattern[i]);
        end
        check(16'(w_flag), 16'h0001);
        check(16'(w_irq), 16'h0001);
        check(16'(state), 16'(ST_DATA));
        for (i = 7; i >= 0; i--)
            tx.bit_out(i[0] ~^ i[2]);
        check(16'(rx_byte), 16'h00A5);
        check(16'(b_flag), 16'h0001);
        check(16'(b_irq), 16'h0001);
        w_ack = 1'h1;
        b_w1c = 1'h1;
        cyc(1);
        w_ack = 1'h0;
        b_w1c = 1'h0;
        cyc(1);
        check(16'({w_flag, w_irq}), 16'h0000);
        check(16'({b_flag, b_irq}), 16'h0000);
        tx.hold(1'h0, 10);
        wait_state(ST_IDLE, 5000);
        check(16'(state), 16'(ST_IDLE));
        tx.preamble(1'h0);
        cyc(5);
    endtask : s_wake_data

    task s_short_burst;
        start_frame(30);
        tx.hold(1'h0, 10);
        wait_state(ST_IDLE, 200);
        check(16'(state), 16'(ST_IDLE));
        check(16'(w_flag), 16'h0000);
        tx.preamble(1'h0);
        cyc(5);
    endtask : s_short_burst

    task s_mode_switch;
        // Mode 00 wakes on the sync edge alone, so a foreign pattern must not matter.
        pattern = ~pattern;
        ctrl.wake_mode_field = 2'h0;
        ctrl.burst_preamble_select = 1'h0;
        tx.preamble(1'h1);
        tx.hold(1'h0, 1300);
        tx.hold(1'h1, 2700);
        tx.hold(1'h0, 10);
        check(16'(state), 16'(ST_DATA));
        check(16'(w_flag), 16'h0001);
        check(16'(w_irq), 16'h0001);
        w_w1c = 1'h1;
        ctrl.wake_irq_mask_bit = 1'h0;
        ctrl.wake_mode_field = 2'h3;
        cyc(1);
        w_w1c = 1'h0;
        cyc(1);
        check(16'(state), 16'(ST_TRANSP));
        check(16'(osc), 16'h0001);
        check(16'({w_flag, w_irq}), 16'h0000);
        ctrl.wake_mode_field = 2'h0;
        cyc(2);
        check(16'(state), 16'(ST_TRANSP));
        ctrl.receiver_enable_bit = 1'h0;
        cyc(2);
        check(16'(state), 16'(ST_IDLE));
        pattern = ~pattern;
        ctrl = 6'h3F;
        ctrl.wake_mode_field = 2'h2;
        tx.preamble(1'h0);
        cyc(5);
    endtask : s_mode_switch

    task s_transparent;
        ctrl.wake_irq_mask_bit = 1'h0;
        ctrl.wake_mode_field = 2'h3;
        tx.preamble(1'h1);
        wait_state(ST_TRANSP, 10);
        check(16'({osc, demod}), 16'h0002);
        tx.hold(1'h1, 5);
        check(16'(demod), 16'h0001);
        tx.hold(1'h0, 4100);
        check(16'(state), 16'(ST_TRANSP));
        fe_rst = 1'h1;
        cyc(1);
        fe_rst = 1'h0;
        cyc(1);
        check(16'({state, osc}), 16'({ST_IDLE, 1'h0}));
        tx.preamble(1'h0);
        ctrl = 6'h3F;
        ctrl.wake_mode_field = 2'h2;
        cyc(5);
    endtask : s_transparent

    initial
    begin
        ctrl.wake_mode_field = 2'h2;
        repeat (20) @(posedge i_clock);
        #1;
        i_rstn = 1'h1;
        cyc(1);
        check(16'({state, w_flag, b_flag, osc}), 16'h0000);
        s_short_burst();
        s_wake_data();
        s_mode_switch();
        s_transparent();
        print_verdict();
    end
endmodule : lfw_sequencer_tb
